// ### cwsp_regs.svh
`ifndef CWSP_REGS_SVH
`define CWSP_REGS_SVH

// Shift register length and field layout
`define CWSP_BITS 17
`define CWSP_SEL_BIT 0
`define CWSP_W1_MSB_BIT 1
`define CWSP_W0_MSB_BIT 9
`define CWSP_WIPER_W 8
`define CWSP_LAST_BIT 16

// Power-up mid-scale wiper code
`define CWSP_WIPER_MID 8'h80
`define CWSP_SEL_RST 1'b0

// Bit buffer depth between sampler and shift register
`define CWSP_FIFO_DEPTH 8

// Longest span, in clocks, from enable rise to load for the frame cover
`define CWSP_FRAME_SPAN 2000

`endif

// ### cwsp_pkg.sv
package cwsp_pkg;

  // Port sequencing, one-hot
  typedef enum logic [2:0] {
    CWSP_IDLE   = 3'h1,
    CWSP_ACTIVE = 3'h2,
    CWSP_FLUSH  = 3'h4
  } cwsp_state_t;

endpackage

// ### cwsp_stream_if.sv
`timescale 1ns/10ps
interface cwsp_stream_if #(parameter int W = 1);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  // Producer side
  modport src (output valid, output data, input ready);
  // Consumer side
  modport snk (input valid, input data, output ready);
endinterface

// ### cwsp_fifo.sv
`timescale 1ns/10ps
module cwsp_fifo #(
  parameter int W = 1,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_b,
  cwsp_stream_if.snk wr,
  cwsp_stream_if.src rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;

  // Handshake decode
  wire do_wr = wr.valid & wr.ready;
  wire do_rd = rd.valid & rd.ready;
  wire [AW-1:0] wr_ptr_nxt = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 :
                             wr_ptr_r + AW'(1);
  wire [AW-1:0] rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 :
                             rd_ptr_r + AW'(1);

  // Honest flags straight from the count
  assign wr.ready = (count_r != CW'(DEPTH));
  assign rd.valid = (count_r != '0);
  assign rd.data = mem_r[rd_ptr_r];

  // Pointers and occupancy
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_wr) wr_ptr_r <= wr_ptr_nxt;
      if (do_rd) rd_ptr_r <= rd_ptr_nxt;
      if (do_wr != do_rd) count_r <= do_wr ? count_r + CW'(1) :
                                             count_r - CW'(1);
    end
  end

  // Storage has no reset; valid masks stale words
  always_ff @(posedge clock) begin
    if (do_wr) mem_r[wr_ptr_r] <= wr.data;
  end
endmodule

// ### cwsp_shift_port.sv
`timescale 1ns/10ps
`include "cwsp_regs.svh"
module cwsp_shift_port #(
  parameter int DEPTH = `CWSP_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic port_en,
  input wire logic ser_clk,
  input wire logic ser_data,
  input wire logic shift_hold,
  output logic cascade_out,
  output logic [`CWSP_WIPER_W-1:0] wiper_zero,
  output logic [`CWSP_WIPER_W-1:0] wiper_one,
  output logic stack_sel,
  output logic [`CWSP_WIPER_W-1:0] stacked_wiper_out,
  output logic overrun
);
  localparam int WW = `CWSP_WIPER_W;

  logic [2:0] en_q;
  logic [2:0] clk_q;
  logic [1:0] dat_q;
  logic [`CWSP_BITS-1:0] sr_r;
  logic [WW-1:0] wiper_zero_r;
  logic [WW-1:0] wiper_one_r;
  logic stack_sel_r;
  logic overrun_r;
  cwsp_pkg::cwsp_state_t state_r;
  cwsp_pkg::cwsp_state_t state_nxt;

  cwsp_stream_if #(.W(1)) push_if ();
  cwsp_stream_if #(.W(1)) pop_if ();

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= '0;
      clk_q <= '0;
      dat_q <= '0;
    end else begin
      en_q <= {en_q[1:0], port_en};
      clk_q <= {clk_q[1:0], ser_clk};
      dat_q <= {dat_q[0], ser_data};
    end
  end

  // Edge detection on the synchronised levels
  wire en_s = en_q[1];
  wire en_rise = en_q[1] & ~en_q[2];
  wire en_fall = ~en_q[1] & en_q[2];
  wire clk_rise = clk_q[1] & ~clk_q[2];

  wire sample = clk_rise & en_s & (state_r == cwsp_pkg::CWSP_ACTIVE);
  assign push_if.valid = sample;
  assign push_if.data = dat_q[1];

  // Drain side; shift_hold lets the buffer really fill
  assign pop_if.ready = ~shift_hold;
  wire pop = pop_if.valid & pop_if.ready;
  wire buf_empty = ~pop_if.valid;
  wire load = (state_r == cwsp_pkg::CWSP_FLUSH) & buf_empty;

  cwsp_fifo #(.W(1), .DEPTH(DEPTH)) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .wr(push_if.snk),
    .rd(pop_if.src)
  );

  // Port sequencing; load waits for buffered bits to drain
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cwsp_pkg::CWSP_IDLE: begin
        if (en_rise) state_nxt = cwsp_pkg::CWSP_ACTIVE;
      end
      cwsp_pkg::CWSP_ACTIVE: begin
        if (en_fall) state_nxt = cwsp_pkg::CWSP_FLUSH;
      end
      cwsp_pkg::CWSP_FLUSH: begin
        if (buf_empty) state_nxt = en_s ? cwsp_pkg::CWSP_ACTIVE :
                                          cwsp_pkg::CWSP_IDLE;
      end
      default: state_nxt = cwsp_pkg::CWSP_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) state_r <= cwsp_pkg::CWSP_IDLE;
    else state_r <= state_nxt;
  end

  // shift in at the top, old bit 0 leaves
  // pure rotation when fed back, nothing lost
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) sr_r <= '0;
    else if (pop) sr_r <= {pop_if.data, sr_r[`CWSP_LAST_BIT:1]};
  end

  // field extraction, MSB at lowest index
  logic [WW-1:0] w0_sr;
  logic [WW-1:0] w1_sr;
  genvar gi;
  generate
    for (gi = 0; gi < WW; gi++) begin : g_field
      assign w1_sr[WW-1-gi] = sr_r[`CWSP_W1_MSB_BIT + gi];
      assign w0_sr[WW-1-gi] = sr_r[`CWSP_W0_MSB_BIT + gi];
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wiper_zero_r <= `CWSP_WIPER_MID;
      wiper_one_r <= `CWSP_WIPER_MID;
      stack_sel_r <= `CWSP_SEL_RST;
    end else if (load) begin
      wiper_zero_r <= w0_sr;
      wiper_one_r <= w1_sr;
      stack_sel_r <= sr_r[`CWSP_SEL_BIT];
    end
  end

  // Sticky: a lost bit corrupts the frame until reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) overrun_r <= 1'b0;
    else if (sample & ~push_if.ready) overrun_r <= 1'b1;
  end

  // select bit (bit 0) always on cascade pin
  assign cascade_out = sr_r[`CWSP_SEL_BIT];
  assign wiper_zero = wiper_zero_r;
  assign wiper_one = wiper_one_r;
  assign stack_sel = stack_sel_r;
  assign overrun = overrun_r;
  assign stacked_wiper_out = stack_sel_r ? wiper_one_r : wiper_zero_r;

  // Cycles since enable rise, saturating; a counter instead of a long range
  localparam int AGE_W = 12;
  logic [AGE_W-1:0] frame_age_r;
  wire age_run = (frame_age_r != '0) & (frame_age_r != '1);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) frame_age_r <= '0;
    else if (en_rise) frame_age_r <= AGE_W'(1);
    else if (age_run) frame_age_r <= frame_age_r + AGE_W'(1);
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_sample_active;
    clk_rise && en_s && state_r == cwsp_pkg::CWSP_ACTIVE && !shift_hold
      |-> ##[1:10] pop;
  endproperty
  a_sample_active: assert property (p_sample_active)
    else $error("enabled clock edge never shifted");

  property p_idle_ignores;
    state_r == cwsp_pkg::CWSP_IDLE |-> !push_if.valid ##1 $stable(sr_r);
  endproperty
  a_idle_ignores: assert property (p_idle_ignores)
    else $error("clock edge taken while port disabled");

  property p_latches_hold;
    !load |=> $stable(wiper_zero) && $stable(wiper_one) && $stable(stack_sel);
  endproperty
  a_latches_hold: assert property (p_latches_hold)
    else $error("wiper latch changed outside load");

  property p_shift_step;
    pop |=> sr_r[`CWSP_LAST_BIT] == $past(pop_if.data) &&
            cascade_out == $past(sr_r[1]);
  endproperty
  a_shift_step: assert property (p_shift_step)
    else $error("shift step wrong");

  property p_cascade_still;
    !pop |=> $stable(cascade_out);
  endproperty
  a_cascade_still: assert property (p_cascade_still)
    else $error("cascade changed without a shift");

  property p_load_fields;
    load |=> wiper_zero == $past(w0_sr) && wiper_one == $past(w1_sr) &&
             stack_sel == $past(sr_r[`CWSP_SEL_BIT]);
  endproperty
  a_load_fields: assert property (p_load_fields)
    else $error("latches not loaded from shift register");

  property p_fall_loads;
    state_r == cwsp_pkg::CWSP_ACTIVE && en_fall && !shift_hold
      |-> ##[1:10] load;
  endproperty
  a_fall_loads: assert property (p_fall_loads)
    else $error("enable fall did not load");

  property p_layout;
    load |=> wiper_one[WW-1] == $past(sr_r[`CWSP_W1_MSB_BIT]) &&
             wiper_zero[0] == $past(sr_r[`CWSP_LAST_BIT]);
  endproperty
  a_layout: assert property (p_layout)
    else $error("field layout wrong");

  property p_reset_mid;
    $rose(rst_b) |-> wiper_zero == `CWSP_WIPER_MID &&
                     wiper_one == `CWSP_WIPER_MID;
  endproperty
  a_reset_mid: assert property (@(posedge clock) p_reset_mid)
    else $error("wipers not mid-scale after reset");

  property p_stack_one;
    stack_sel |-> stacked_wiper_out == wiper_one;
  endproperty
  a_stack_one: assert property (p_stack_one)
    else $error("stacked output not wiper one");

  property p_cv_load_sel;
    load && sr_r[`CWSP_SEL_BIT];
  endproperty
  c_load_sel: cover property (p_cv_load_sel);

  property p_cv_full;
    !push_if.ready;
  endproperty
  c_full: cover property (p_cv_full);

  property p_cv_frame;
    load && frame_age_r != '0 &&
      frame_age_r <= AGE_W'(`CWSP_FRAME_SPAN);
  endproperty
  c_frame: cover property (p_cv_frame);
endmodule

// ### cwsp_host_model.sv
`timescale 1ns/10ps
module cwsp_host_model (
  input wire logic clock,
  input wire logic cascade_out,
  output logic port_en,
  output logic ser_clk,
  output logic ser_data
);
  logic [16:0] seen;
  logic loop_on;
  initial begin
    port_en = 1'b0;
    ser_clk = 1'b0;
    ser_data = 1'b0;
    loop_on = 1'b0;
    seen = 17'h0;
  end
  always @(cascade_out) begin
    #1;
    if (loop_on) begin
      ser_data = cascade_out;
    end
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // One frame of n edges; clock stands still outside frames
  task automatic frame(input logic [16:0] f, input int n,
                       input logic en, input logic loop);
    int k;
    wait_clk(1);
    port_en = en;
    loop_on = loop;
    if (loop) begin
      ser_data = cascade_out;
    end
    wait_clk(8);
    for (k = 0; k < n; k++) begin
      if (!loop) begin
        ser_data = f[16 - (k % 17)];
      end
      wait_clk(4);
      seen = {seen[15:0], cascade_out};
      ser_clk = 1'b1;
      wait_clk(4);
      ser_clk = 1'b0;
    end
    wait_clk(4);
    port_en = 1'b0;
    loop_on = 1'b0;
    // Released line must not keep its last value
    ser_data = ~ser_data;
    wait_clk(24);
  endtask
endmodule

// ### cascaded_wiper_shift_port_tb_top.sv
`timescale 1ns/10ps
`include "cwsp_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module cascaded_wiper_shift_port_tb_top;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic shift_hold = 1'b0;
  logic port_en, ser_clk, ser_data, cascade_out, stack_sel, overrun;
  logic [`CWSP_WIPER_W-1:0] wiper_zero, wiper_one, stacked_wiper_out;
  logic [16:0] last_f = 17'h0;
  int n_errors = 0;
  int total_checks = 0;
  always #10 clock = ~clock;
  cwsp_shift_port i_dut (.clock(clock), .rst_b(rst_b), .port_en(port_en),
    .ser_clk(ser_clk), .ser_data(ser_data), .shift_hold(shift_hold),
    .cascade_out(cascade_out), .wiper_zero(wiper_zero),
    .wiper_one(wiper_one), .stack_sel(stack_sel),
    .stacked_wiper_out(stacked_wiper_out), .overrun(overrun));
  cwsp_host_model i_host (.clock(clock), .cascade_out(cascade_out),
    .port_en(port_en), .ser_clk(ser_clk), .ser_data(ser_data));
  task automatic complete_run();
    $display("Checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Latches against the last full frame sent
  task automatic chk_latch();
    `CHK("wiper_zero", last_f[7:0], wiper_zero)
    `CHK("wiper_one", last_f[15:8], wiper_one)
    `CHK("stack_sel", last_f[16], stack_sel)
    `CHK("stacked", last_f[16] ? last_f[15:8] : last_f[7:0],
      stacked_wiper_out)
    `CHK("cascade_idle", last_f[16], cascade_out)
  endtask
  task automatic t_reset();
    `CHK("wiper_zero", `CWSP_WIPER_MID, wiper_zero)
    `CHK("wiper_one", `CWSP_WIPER_MID, wiper_one)
    `CHK("stacked", `CWSP_WIPER_MID, stacked_wiper_out)
    `CHK("overrun", 1'b0, overrun)
  endtask
  // Old contents leave on cascade, select bit first
  task automatic t_write(input logic [16:0] f);
    i_host.frame(f, 17, 1'b1, 1'b0);
    `CHK("cascade_stream", last_f, i_host.seen)
    last_f = f;
    chk_latch();
  endtask
  task automatic t_ignored();
    i_host.frame(~last_f, 17, 1'b0, 1'b0);
    chk_latch();
  endtask
  // Looped readback keeps contents and wipers
  task automatic t_readback();
    i_host.frame(17'h0, 17, 1'b1, 1'b1);
    `CHK("readback", last_f, i_host.seen)
    chk_latch();
  endtask
  // Stalled drain overflows the bit buffer
  task automatic t_overrun();
    @(posedge clock);
    #1 shift_hold = 1'b1;
    i_host.frame(17'h15555, 17, 1'b1, 1'b0);
    `CHK("overrun_set", 1'b1, overrun)
    shift_hold = 1'b0;
    i_host.wait_clk(40);
    `CHK("overrun_sticky", 1'b1, overrun)
  endtask
  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (4) @(posedge clock);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_write({1'b0, 8'h3c, 8'ha5});
    t_write({1'b1, 8'h5a, 8'h01});
    t_write({1'b1, 8'hff, 8'h80});
    t_ignored();
    t_readback();
    t_overrun();
    complete_run();
  end
endmodule
